// ==== verilog/fciei_pkg.sv ====
// package: constants for the four-channel input edge interrupt block
package fciei_pkg;
    localparam int NUM_CH = 4;
    localparam int CLK_MHZ = 25;
    // parameter byte indices on the parameter write port
    localparam logic [3:0] IDX_DIAG_EN = 4'h0;
    localparam logic [3:0] IDX_DELAY_CH0 = 4'h1;
    localparam logic [3:0] IDX_DELAY_CH3 = 4'h4;
    localparam logic [3:0] IDX_RISE_MASK = 4'h5;
    localparam logic [3:0] IDX_FALL_MASK = 4'h6;
    // reset values
    localparam logic [7:0] RST_DIAG_EN = 8'h00;
    localparam logic [7:0] RST_DELAY = 8'h02;
    localparam logic [7:0] RST_MASK = 8'h00;
    // diagnostic enable codes
    localparam logic [7:0] DIAG_OFF = 8'h00;
    localparam logic [7:0] DIAG_ON = 8'h40;
    // filter delay codes
    localparam logic [7:0] DLY_1US = 8'h00;
    localparam logic [7:0] DLY_3US = 8'h02;
    localparam logic [7:0] DLY_10US = 8'h04;
    localparam logic [7:0] DLY_86US = 8'h07;
    localparam logic [7:0] DLY_342US = 8'h09;
    localparam logic [7:0] DLY_2731US = 8'h0C;
    // filter times in microseconds
    localparam int T_1US = 1;
    localparam int T_3US = 3;
    localparam int T_10US = 10;
    localparam int T_86US = 86;
    localparam int T_342US = 342;
    localparam int T_2731US = 2731;
    // diagnostic status bit positions
    localparam int DIAG_BIT_OVF = 3;
    localparam int DIAG_BIT_LOST = 6;
    // clocks per microsecond tick
    localparam int US_DIV = CLK_MHZ;
    localparam int TICK_W = 32;
    localparam int TS_W = 16;
    localparam int FLT_CNT_W = 12;
endpackage : fciei_pkg

// ==== verilog/fciei_filter.sv ====
// file: one channel input delay filter counted in microsecond ticks
`timescale 1ns/1ps
module fciei_filter
    import fciei_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_rst_n, // synchronised reset, low active
    input wire logic i_us_tick, // one-cycle pulse per microsecond
    input wire logic [7:0] i_delay_code, // delay byte of this channel
    input wire logic i_raw, // raw input level
    output logic o_filt // filtered level
);
    logic [FLT_CNT_W-1:0] cnt_reg;
    logic [FLT_CNT_W-1:0] limit;

    function automatic logic [FLT_CNT_W-1:0] delay_us(input logic [7:0] code);
        case (code)
            DLY_1US: delay_us = FLT_CNT_W'(T_1US);
            DLY_3US: delay_us = FLT_CNT_W'(T_3US);
            DLY_10US: delay_us = FLT_CNT_W'(T_10US);
            DLY_86US: delay_us = FLT_CNT_W'(T_86US);
            DLY_342US: delay_us = FLT_CNT_W'(T_342US);
            DLY_2731US: delay_us = FLT_CNT_W'(T_2731US);
            // codes outside the list fall back to the default filter
            default: delay_us = FLT_CNT_W'(T_3US);
        endcase
    endfunction : delay_us

    assign limit = delay_us(i_delay_code);

    // level must differ from output for the whole delay before it passes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
            o_filt <= 1'b0;
        end else if (i_raw == o_filt) begin
            cnt_reg <= '0;
        end else if (i_us_tick) begin
            if (cnt_reg + FLT_CNT_W'(1) >= limit) begin
                o_filt <= i_raw;
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + FLT_CNT_W'(1);
            end
        end
    end

    AST_SPIKE_REJECT: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $changed(o_filt) |-> $past(i_raw) == o_filt)
        else $error("filter output took a level the input did not hold");
endmodule : fciei_filter

// ==== verilog/fciei_top.sv ====
// file: four-channel input block with edge events, timestamp, diagnostics
// Function
// - diagnostic interrupt function off at 00h, on at 40h.
// - each channel filters its input with delay chosen by its byte.
// - rising mask bits 0-3 enable low-to-high interrupts per channel.
// - falling mask bits 0-3 enable high-to-low interrupts per channel.
// - enabled edges raise a process interrupt, a diagnostic one only when lost.
// - edge flag bit n set when channel n edge caused interrupt.
// - all four input levels captured at the interrupt moment.
// - record carried as emergency or diagnostic message by fieldbus.
// - free-running 32-bit microsecond counter from zero, wrapping.
// - timestamp holds low 16 counter bits at interrupt time.
// - diagnostic buffer overflow sets status bit 3, diagnostic interrupt.
// - lost process interrupt sets status bit 6, diagnostic interrupt.
`timescale 1ns/1ps
module fciei_top
    import fciei_pkg::*;
#(
    parameter int N_CH = NUM_CH // channel count
)
(
    input wire logic I_CLK, // 25 MHz clock
    input wire logic I_RSTN, // async reset, low active
    input wire logic [N_CH-1:0] I_INPUT_CHANNEL_N, // raw digital inputs
    input wire logic I_PARAM_WR, // parameter byte write strobe
    input wire logic [3:0] I_PARAM_IDX, // parameter byte index
    input wire logic [7:0] I_PARAM_DATA, // parameter byte value
    input wire logic I_CANOPEN_SEL, // 1: attached over CANopen
    input wire logic I_RECORD_ACK, // coupler took the pending record
    input wire logic I_DIAG_BUF_OVF, // internal diag buffer overflow pulse
    input wire logic I_DIAG_ACK, // coupler took the diagnostic record
    output logic O_PROC_IRQ, // process interrupt record pending
    output logic O_PROC_EMCY, // pending record goes as emergency msg
    output logic O_PROC_DIAG_MSG, // pending record goes as diag message
    output logic [7:0] O_EDGE_EVENT_FLAGS, // edge flag byte
    output logic [7:0] O_INPUT_STATE_SNAPSHOT, // input state byte
    output logic [15:0] O_EVENT_TIMESTAMP_LOW, // timestamp field
    output logic O_DIAG_IRQ, // diagnostic interrupt pending
    output logic [7:0] O_DIAG_STATUS, // diagnostic status byte
    output logic [31:0] O_US_TICKER, // microsecond counter
    output logic [7:0] O_DIAG_ENABLE, // diagnostic enable byte readback
    output logic [7:0] O_RISE_MASK, // rising mask readback
    output logic [7:0] O_FALL_MASK // falling mask readback
);
    logic rst_meta_reg;
    logic rst_n_reg;
    logic [7:0] delay_reg [N_CH];
    logic [7:0] diag_en_reg;
    logic [7:0] rise_reg;
    logic [7:0] fall_reg;
    logic [4:0] div_reg;
    logic us_tick_reg;
    logic [TICK_W-1:0] ticker_reg;
    logic [N_CH-1:0] filt;
    logic [N_CH-1:0] filt_d_reg;
    logic [N_CH-1:0] hits;
    logic lost_pulse;
    logic diag_evt;

    // reset release through two flops
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // parameter bytes; delay codes outside the list are trusted to the master
    always_ff @(posedge I_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            diag_en_reg <= RST_DIAG_EN;
            rise_reg <= RST_MASK;
            fall_reg <= RST_MASK;
            for (int i = 0; i < N_CH; i++) begin
                delay_reg[i] <= RST_DELAY;
            end
        end else if (I_PARAM_WR) begin
            if (I_PARAM_IDX == IDX_DIAG_EN) begin
                diag_en_reg <= I_PARAM_DATA;
            end else if (I_PARAM_IDX >= IDX_DELAY_CH0 &&
                         I_PARAM_IDX <= IDX_DELAY_CH3) begin
                delay_reg[2'(I_PARAM_IDX - IDX_DELAY_CH0)] <= I_PARAM_DATA;
            end else if (I_PARAM_IDX == IDX_RISE_MASK) begin
                rise_reg <= {4'h0, I_PARAM_DATA[3:0]};
            end else if (I_PARAM_IDX == IDX_FALL_MASK) begin
                fall_reg <= {4'h0, I_PARAM_DATA[3:0]};
            end
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_DIAG_ENABLE <= RST_DIAG_EN;
            O_RISE_MASK <= RST_MASK;
            O_FALL_MASK <= RST_MASK;
        end else begin
            O_DIAG_ENABLE <= diag_en_reg;
            O_RISE_MASK <= rise_reg;
            O_FALL_MASK <= fall_reg;
        end
    end

    // microsecond tick and 32-bit ticker, wraps naturally
    always_ff @(posedge I_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            div_reg <= '0;
            us_tick_reg <= 1'b0;
            ticker_reg <= '0;
        end else begin
            us_tick_reg <= (div_reg == 5'(US_DIV - 1));
            if (div_reg == 5'(US_DIV - 1)) begin
                div_reg <= '0;
                ticker_reg <= ticker_reg + TICK_W'(1);
            end else begin
                div_reg <= div_reg + 5'h1;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_US_TICKER <= '0;
        end else begin
            O_US_TICKER <= ticker_reg;
        end
    end

    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        fciei_filter u_filter (
            .i_clk(I_CLK),
            .i_rst_n(rst_n_reg),
            .i_us_tick(us_tick_reg),
            .i_delay_code(delay_reg[c]),
            .i_raw(I_INPUT_CHANNEL_N[c]),
            .o_filt(filt[c])
        );
    end

    always_ff @(posedge I_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            filt_d_reg <= '0;
        end else begin
            filt_d_reg <= filt;
        end
    end

    // edges seen after the filter only
    assign hits = (filt & ~filt_d_reg & rise_reg[N_CH-1:0])
                | (~filt & filt_d_reg & fall_reg[N_CH-1:0]);
    // a new edge while the previous record is still unacknowledged is lost
    assign lost_pulse = (|hits) && O_PROC_IRQ && !I_RECORD_ACK;

    // single-entry record; first record kept, later edges counted as lost
    always_ff @(posedge I_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_PROC_IRQ <= 1'b0;
            O_PROC_EMCY <= 1'b0;
            O_PROC_DIAG_MSG <= 1'b0;
            O_EDGE_EVENT_FLAGS <= '0;
            O_INPUT_STATE_SNAPSHOT <= '0;
            O_EVENT_TIMESTAMP_LOW <= '0;
        end else if (|hits && (!O_PROC_IRQ || I_RECORD_ACK)) begin
            O_PROC_IRQ <= 1'b1;
            O_PROC_EMCY <= I_CANOPEN_SEL;
            O_PROC_DIAG_MSG <= !I_CANOPEN_SEL;
            O_EDGE_EVENT_FLAGS <= 8'(hits);
            O_INPUT_STATE_SNAPSHOT <= 8'(filt);
            O_EVENT_TIMESTAMP_LOW <= ticker_reg[TS_W-1:0];
        end else if (I_RECORD_ACK) begin
            O_PROC_IRQ <= 1'b0;
            O_PROC_EMCY <= 1'b0;
            O_PROC_DIAG_MSG <= 1'b0;
        end
    end

    // diagnostic status: set wins over acknowledge
    assign diag_evt = I_DIAG_BUF_OVF || lost_pulse;
    always_ff @(posedge I_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_DIAG_STATUS <= '0;
            O_DIAG_IRQ <= 1'b0;
        end else begin
            if (I_DIAG_BUF_OVF) begin
                O_DIAG_STATUS[DIAG_BIT_OVF] <= 1'b1;
            end else if (I_DIAG_ACK) begin
                O_DIAG_STATUS[DIAG_BIT_OVF] <= 1'b0;
            end
            if (lost_pulse) begin
                O_DIAG_STATUS[DIAG_BIT_LOST] <= 1'b1;
            end else if (I_DIAG_ACK) begin
                O_DIAG_STATUS[DIAG_BIT_LOST] <= 1'b0;
            end
            if (diag_evt && diag_en_reg == DIAG_ON) begin
                O_DIAG_IRQ <= 1'b1;
            end else if (I_DIAG_ACK || diag_en_reg == DIAG_OFF) begin
                O_DIAG_IRQ <= 1'b0;
            end
        end
    end

    sequence s_edge_taken;
        (|hits) && !O_PROC_IRQ;
    endsequence
    sequence s_record_out;
        ##1 O_PROC_IRQ && O_EDGE_EVENT_FLAGS == 8'($past(hits));
    endsequence

    AST_EDGE_RECORD: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        s_edge_taken |-> s_record_out)
        else $error("edge flags not recorded from enabled edge");
    // a flagged channel that rose must have had its rising bit set
    AST_RISE_MASKED: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        s_edge_taken |=> (O_EDGE_EVENT_FLAGS[N_CH-1:0] & filt_d_reg
            & ~$past(rise_reg[N_CH-1:0])) == '0)
        else $error("disabled rising edge produced event");
    AST_FALL_MASKED: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        s_edge_taken |=> (O_EDGE_EVENT_FLAGS[N_CH-1:0] & ~filt_d_reg
            & ~$past(fall_reg[N_CH-1:0])) == '0)
        else $error("disabled falling edge produced event");
    AST_SNAPSHOT: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        s_edge_taken |=> O_INPUT_STATE_SNAPSHOT[3:0] == $past(filt))
        else $error("input snapshot mismatch");
    AST_TIMESTAMP: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        s_edge_taken |=> O_EVENT_TIMESTAMP_LOW == $past(ticker_reg[15:0]))
        else $error("timestamp not low ticker bits");
    // the tick flag and the ticker step land on the same edge
    AST_TICKER_STEP: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        ticker_reg == $past(ticker_reg) + TICK_W'(us_tick_reg))
        else $error("ticker stepped off the microsecond boundary");
    AST_PROC_NOT_DIAG: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        ((|hits) && !O_PROC_IRQ && !diag_evt && !O_DIAG_IRQ) |=> !O_DIAG_IRQ)
        else $error("edge raised a diagnostic interrupt");
    AST_OVF_BIT: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        I_DIAG_BUF_OVF |=> O_DIAG_STATUS[DIAG_BIT_OVF])
        else $error("overflow bit not set");
    AST_LOST_BIT: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        lost_pulse |=> O_DIAG_STATUS[DIAG_BIT_LOST] && O_PROC_IRQ)
        else $error("lost interrupt bit not set");
    AST_DIAG_OFF: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        diag_en_reg == DIAG_OFF |=> !O_DIAG_IRQ)
        else $error("diagnostic interrupt while disabled");
    AST_MSG_KIND: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        O_PROC_IRQ |-> O_PROC_EMCY != O_PROC_DIAG_MSG)
        else $error("record message kind not exclusive");
    // a pending record must not be overwritten before the coupler takes it
    AST_RECORD_HOLD: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        (O_PROC_IRQ && !I_RECORD_ACK) |=> $stable(O_EDGE_EVENT_FLAGS)
            && $stable(O_INPUT_STATE_SNAPSHOT)
            && $stable(O_EVENT_TIMESTAMP_LOW))
        else $error("pending record changed before acknowledge");
    AST_RECORD_ACK: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        (O_PROC_IRQ && I_RECORD_ACK && !(|hits)) |=> !O_PROC_IRQ)
        else $error("acknowledged record still pending");
    AST_RESERVED_ZERO: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        O_EDGE_EVENT_FLAGS[7:4] == 4'h0
            && O_INPUT_STATE_SNAPSHOT[7:4] == 4'h0)
        else $error("reserved record bits set");
    AST_MASK_RESERVED: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        O_RISE_MASK[7:4] == 4'h0 && O_FALL_MASK[7:4] == 4'h0)
        else $error("reserved mask bits read back set");
    AST_READBACK: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        O_DIAG_ENABLE == $past(diag_en_reg))
        else $error("diagnostic enable readback differs");
    AST_TICKER_OUT: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        O_US_TICKER == $past(ticker_reg))
        else $error("ticker output not one cycle behind");
    // both diagnostic events reach the interrupt while the function is on
    AST_OVF_IRQ: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        (I_DIAG_BUF_OVF && diag_en_reg == DIAG_ON) |=> O_DIAG_IRQ)
        else $error("overflow raised no diagnostic interrupt");
    AST_LOST_IRQ: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        (lost_pulse && diag_en_reg == DIAG_ON) |=> O_DIAG_IRQ)
        else $error("lost record raised no diagnostic interrupt");
    AST_DIAG_CLEAR: assert property (
        @(posedge I_CLK) disable iff (!rst_n_reg)
        (I_DIAG_ACK && !diag_evt) |=> !O_DIAG_IRQ
            && O_DIAG_STATUS[DIAG_BIT_OVF] == 1'b0
            && O_DIAG_STATUS[DIAG_BIT_LOST] == 1'b0)
        else $error("diagnostic acknowledge left status set");
endmodule : fciei_top

// ==== tb/fciei_coupler_model.sv ====
// bus coupler model: parameter byte writes and record acknowledges
`timescale 1ns/1ps
module fciei_coupler_model
    import fciei_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_hold, // 1: leave pending records unacknowledged
    input wire logic i_proc_irq, // process record pending
    input wire logic i_diag_irq, // diagnostic record pending
    output logic o_param_wr, // parameter write strobe
    output logic [3:0] o_param_idx, // parameter byte index
    output logic [7:0] o_param_data, // parameter byte value
    output logic o_record_ack, // process record taken
    output logic o_diag_ack // diagnostic record taken
);
    initial begin
        o_param_wr = 1'b0;
        o_param_idx = 4'h0;
        o_param_data = 8'h00;
        o_record_ack = 1'b0;
        o_diag_ack = 1'b0;
    end
    // one-cycle acks, never while the bench holds records back
    always @(posedge i_clk) begin
        o_record_ack <= i_proc_irq && !i_hold && !o_record_ack;
        o_diag_ack <= i_diag_irq && !i_hold && !o_diag_ack;
    end
    // called by the bench while configuring and also mid-test, to cut the running channel 2 delay
    task automatic write_param(input logic [3:0] idx,
                               input logic [7:0] data);
        if (idx >= IDX_DELAY_CH0 && idx <= IDX_DELAY_CH3 && !(data inside
            {DLY_1US, DLY_3US, DLY_10US, DLY_86US, DLY_342US,
             DLY_2731US})) begin
            return;
        end
        @(posedge i_clk);
        o_param_wr <= 1'b1;
        o_param_idx <= idx;
        o_param_data <= data;
        @(posedge i_clk);
        o_param_wr <= 1'b0;
        // idle data must not look like a held value
        o_param_data <= ~data;
    endtask : write_param
endmodule : fciei_coupler_model

// ==== tb/fciei_top_tb.sv ====
// testbench for the four-channel input edge interrupt block
`timescale 1ns/1ps
module fciei_top_tb
    import fciei_pkg::*;
;
    logic I_CLK, I_RSTN, I_CANOPEN_SEL, I_DIAG_BUF_OVF, hold;
    logic [3:0] in_reg;
    logic wr, rack, dack;
    logic [3:0] idx;
    logic [7:0] dat;
    logic O_PROC_IRQ, O_PROC_EMCY, O_PROC_DIAG_MSG, O_DIAG_IRQ;
    logic [7:0] O_EDGE_EVENT_FLAGS, O_INPUT_STATE_SNAPSHOT, O_DIAG_STATUS;
    logic [7:0] O_DIAG_ENABLE, O_RISE_MASK, O_FALL_MASK;
    logic [15:0] O_EVENT_TIMESTAMP_LOW;
    logic [31:0] O_US_TICKER;
    int n_mismatch = 0, n_checks = 0, cyc_cnt = 0, cyc, i;
    int codes[5] = '{DLY_1US, DLY_3US, DLY_10US, DLY_86US, DLY_342US};
    int times[5] = '{T_1US, T_3US, T_10US, T_86US, T_342US};

    fciei_top uut (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
        .I_INPUT_CHANNEL_N(in_reg), .I_PARAM_WR(wr), .I_PARAM_IDX(idx),
        .I_PARAM_DATA(dat), .I_CANOPEN_SEL(I_CANOPEN_SEL),
        .I_RECORD_ACK(rack), .I_DIAG_BUF_OVF(I_DIAG_BUF_OVF),
        .I_DIAG_ACK(dack), .O_PROC_IRQ(O_PROC_IRQ),
        .O_PROC_EMCY(O_PROC_EMCY), .O_PROC_DIAG_MSG(O_PROC_DIAG_MSG),
        .O_EDGE_EVENT_FLAGS(O_EDGE_EVENT_FLAGS),
        .O_INPUT_STATE_SNAPSHOT(O_INPUT_STATE_SNAPSHOT),
        .O_EVENT_TIMESTAMP_LOW(O_EVENT_TIMESTAMP_LOW),
        .O_DIAG_IRQ(O_DIAG_IRQ), .O_DIAG_STATUS(O_DIAG_STATUS),
        .O_US_TICKER(O_US_TICKER), .O_DIAG_ENABLE(O_DIAG_ENABLE),
        .O_RISE_MASK(O_RISE_MASK), .O_FALL_MASK(O_FALL_MASK));
    fciei_coupler_model cpl (.i_clk(I_CLK), .i_hold(hold),
        .i_proc_irq(O_PROC_IRQ), .i_diag_irq(O_DIAG_IRQ),
        .o_param_wr(wr), .o_param_idx(idx), .o_param_data(dat),
        .o_record_ack(rack), .o_diag_ack(dack));

    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end
    // reference clock-cycle count, runs ahead of the synced reset copy
    always @(posedge I_CLK) if (I_RSTN) cyc_cnt <= cyc_cnt + 1;

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // bounded wait for a pending flag to reach a level
    task automatic wait_sig(input bit diag, input logic want, input int mx);
        cyc = 0;
        while ((diag ? O_DIAG_IRQ : O_PROC_IRQ) !== want) begin
            @(posedge I_CLK);
            #1;
            cyc++;
            if (cyc > mx) begin
                check(~want, want);
                close_out();
            end
        end
    endtask : wait_sig
    task automatic set_in(input logic [3:0] v, input logic sel);
        @(posedge I_CLK);
        in_reg <= v;
        I_CANOPEN_SEL <= sel;
        #1;
    endtask : set_in
    task automatic ack_rec();
        @(posedge I_CLK);
        hold <= 1'b0;
        wait_sig(0, 1'b0, 10);
        @(posedge I_CLK);
        hold <= 1'b1;
    endtask : ack_rec
    task automatic pulse_ovf();
        @(posedge I_CLK);
        I_DIAG_BUF_OVF <= 1'b1;
        @(posedge I_CLK);
        I_DIAG_BUF_OVF <= 1'b0;
        repeat (3) @(posedge I_CLK);
        #1;
    endtask : pulse_ovf
    task automatic chk_time();
        logic [31:0] d;
        d = (cyc_cnt / US_DIV) - O_US_TICKER;
        check(d <= 1, 1);
        d = 16'(cyc_cnt / US_DIV) - O_EVENT_TIMESTAMP_LOW;
        check(16'(d) <= 16'h0002, 1);
    endtask : chk_time

    initial begin
        I_RSTN = 1'b0;
        in_reg = 4'h0;
        I_CANOPEN_SEL = 1'b0;
        I_DIAG_BUF_OVF = 1'b0;
        hold = 1'b1;
        repeat (6) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        repeat (4) @(posedge I_CLK);
        #1;
        check(O_DIAG_ENABLE, RST_DIAG_EN);
        check(O_RISE_MASK, RST_MASK);
        check(O_FALL_MASK, RST_MASK);
        check(O_DIAG_STATUS, 8'h00);
        cpl.write_param(IDX_DIAG_EN, DIAG_ON);
        cpl.write_param(IDX_RISE_MASK, 8'h0F);
        for (i = 0; i < 4; i++) begin
            cpl.write_param(IDX_DELAY_CH0 + 4'(i), DLY_1US);
        end
        repeat (2) @(posedge I_CLK);
        #1;
        check(O_DIAG_ENABLE, DIAG_ON);
        check(O_RISE_MASK, 8'h0F);
        // one rising record per channel, message kind alternating
        for (i = 0; i < 4; i++) begin
            set_in(in_reg | (4'h1 << i), i[0]);
            wait_sig(0, 1'b1, 120);
            check(O_EDGE_EVENT_FLAGS, 8'h01 << i);
            check(O_INPUT_STATE_SNAPSHOT, {4'h0, in_reg});
            check({O_PROC_EMCY, O_PROC_DIAG_MSG}, {i[0], !i[0]});
            check(O_DIAG_IRQ, 1'b0);
            chk_time();
            ack_rec();
        end
        cpl.write_param(IDX_RISE_MASK, 8'h00);
        cpl.write_param(IDX_FALL_MASK, 8'hFF);
        repeat (2) @(posedge I_CLK);
        #1;
        check(O_FALL_MASK, 8'h0F);
        set_in(4'h0, 1'b0);
        wait_sig(0, 1'b1, 120);
        check(O_EDGE_EVENT_FLAGS, 8'h0F);
        check(O_INPUT_STATE_SNAPSHOT, 8'h00);
        ack_rec();
        // masked rise gives nothing, unmasked fall still reports
        set_in(4'h1, 1'b0);
        repeat (150) @(posedge I_CLK);
        check(O_PROC_IRQ, 1'b0);
        set_in(4'h0, 1'b0);
        wait_sig(0, 1'b1, 120);
        check(O_EDGE_EVENT_FLAGS, 8'h01);
        ack_rec();
        // short spike on a 3 us channel is filtered away
        cpl.write_param(IDX_RISE_MASK, 8'h0F);
        cpl.write_param(IDX_DELAY_CH0 + 4'h1, DLY_3US);
        set_in(4'h2, 1'b0);
        repeat (4) @(posedge I_CLK);
        set_in(4'h0, 1'b0);
        repeat (200) @(posedge I_CLK);
        check(O_PROC_IRQ, 1'b0);
        // filter delay per code up to 342 us, measured on channel 2
        for (i = 0; i < 5; i++) begin
            cpl.write_param(IDX_DELAY_CH0 + 4'h2, 8'(codes[i]));
            set_in(4'h4, 1'b0);
            wait_sig(0, 1'b1, times[i] * US_DIV + 60);
            check(cyc >= (times[i] - 1) * US_DIV, 1);
            check(cyc <= times[i] * US_DIV + 10, 1);
            ack_rec();
            set_in(4'h0, 1'b0);
            wait_sig(0, 1'b1, times[i] * US_DIV + 60);
            ack_rec();
        end
        // longest code still blocks the level long after 342 us
        cpl.write_param(IDX_DELAY_CH0 + 4'h2, DLY_2731US);
        set_in(4'h4, 1'b0);
        repeat (400 * US_DIV) @(posedge I_CLK);
        check(O_PROC_IRQ, 1'b0);
        cpl.write_param(IDX_DELAY_CH0 + 4'h2, DLY_1US);
        wait_sig(0, 1'b1, 60);
        check(O_EDGE_EVENT_FLAGS, 8'h04);
        ack_rec();
        set_in(4'h0, 1'b0);
        wait_sig(0, 1'b1, 60);
        check(O_EDGE_EVENT_FLAGS, 8'h04);
        ack_rec();
        // second edge while a record stands is lost
        set_in(4'h1, 1'b0);
        wait_sig(0, 1'b1, 120);
        set_in(4'h0, 1'b0);
        wait_sig(1, 1'b1, 120);
        check(O_DIAG_STATUS[DIAG_BIT_LOST], 1'b1);
        check(O_EDGE_EVENT_FLAGS, 8'h01);
        pulse_ovf();
        check(O_DIAG_STATUS[DIAG_BIT_OVF], 1'b1);
        ack_rec();
        wait_sig(1, 1'b0, 10);
        check(O_DIAG_STATUS, 8'h00);
        cpl.write_param(IDX_DIAG_EN, DIAG_OFF);
        pulse_ovf();
        check(O_DIAG_STATUS[DIAG_BIT_OVF], 1'b1);
        check(O_DIAG_IRQ, 1'b0);
        close_out();
    end
endmodule : fciei_top_tb
